// File: ltrx_line_ctrl.sv
// line tristate control and receive system-side data outputs for all channels
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module ltrx_line_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic recoveredRxClock,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ltrx_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxImpedancePin,
  input wire logic txOutputEnablePin,
  input wire logic [ltrx_pkg::NCH-1:0] txLineClockIn,
  input wire logic [ltrx_pkg::NCH-1:0] txOvercurrent,
  input wire logic [ltrx_pkg::NCH-1:0] rxDecodedData,
  input wire logic [ltrx_pkg::NCH-1:0] rxPosRailIn,
  input wire logic [ltrx_pkg::NCH-1:0] rxNegRailIn,
  output logic [ltrx_pkg::NCH-1:0] rxLineHiZ,
  output logic [ltrx_pkg::NCH-1:0] txLineOeN,
  output logic [ltrx_pkg::NCH-1:0] rxPosRailOut,
  output logic [ltrx_pkg::NCH-1:0] rxNegRailOut,
  output logic [ltrx_pkg::NCH-1:0] rxDataOeN,
  output logic internalTimingClock
);
  import ltrx_pkg::*;

  // ===========================================================================
  // reset synchronisers, one per clock domain
  logic [1:0] rstPipe;
  logic rstSyncN;
  logic [1:0] linkRstPipe;
  logic linkRstN;
  assign rstSyncN = rstPipe[1];
  assign linkRstN = linkRstPipe[1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rstPipe <= 2'b00;
    else rstPipe <= {rstPipe[0], 1'b1};
  end

  always_ff @(posedge recoveredRxClock or negedge rst_n) begin
    if (!rst_n) linkRstPipe <= 2'b00;
    else linkRstPipe <= {linkRstPipe[0], 1'b1};
  end

  // ===========================================================================
  // address decode helpers
  function automatic logic chanHit(input logic [AW-1:0] a, input logic [AW-1:0] base);
    chanHit = (a[AW-1:7] == base[AW-1:7]) && (a[6:2] < 5'(NCH)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [4:0] chanOf(input logic [AW-1:0] a);
    chanOf = a[6:2];
  endfunction

  // ===========================================================================
  // configuration registers (master clock domain)
  logic [7:0] rxCfgA [NCH];
  logic [7:0] rxCfgB [NCH];
  logic [7:0] txCfgA [NCH];
  logic [7:0] txMode [NCH];
  logic lineEnable;
  logic swResetPulse;
  logic wrEn;
  logic [4:0] wrCh;
  assign wrEn = psel && penable && pready && pwrite && !pslverr;
  assign wrCh = chanOf(paddr);

  // per-channel registers; a channel reset holds that channel's rx config A/B and tx config A at default, its tx mode stays writable
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      for (int i = 0; i < NCH; i++) begin
        rxCfgA[i] <= CFG_RESET;
        rxCfgB[i] <= CFG_RESET;
        txCfgA[i] <= CFG_RESET;
        txMode[i] <= CFG_RESET;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (swResetPulse) begin
          rxCfgA[i] <= CFG_RESET;
          rxCfgB[i] <= CFG_RESET;
          txCfgA[i] <= CFG_RESET;
          txMode[i] <= CFG_RESET;
        end else begin
          if (txMode[i][TXM_CH_RST_BIT]) begin
            rxCfgA[i] <= CFG_RESET;
            rxCfgB[i] <= CFG_RESET;
            txCfgA[i] <= CFG_RESET;
          end else if (wrEn && wrCh == 5'(i)) begin
            if (chanHit(paddr, RX_CFG_A_BASE)) rxCfgA[i] <= pwdata[7:0];
            if (chanHit(paddr, RX_CFG_B_BASE)) rxCfgB[i] <= pwdata[7:0];
            if (chanHit(paddr, TX_CFG_A_BASE)) txCfgA[i] <= pwdata[7:0];
          end
          if (wrEn && wrCh == 5'(i) && chanHit(paddr, TX_MODE_BASE)) txMode[i] <= pwdata[7:0];
        end
      end
    end
  end

  // global control; software reset is a one-cycle pulse that also drops line enable
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lineEnable <= GC_LINE_EN_RESET;
      swResetPulse <= 1'b0;
    end else begin
      swResetPulse <= wrEn && paddr == GLOBAL_CTRL_OFS && pwdata[GC_SW_RST_BIT];
      if (swResetPulse) lineEnable <= GC_LINE_EN_RESET;
      else if (wrEn && paddr == GLOBAL_CTRL_OFS) lineEnable <= pwdata[GC_LINE_EN_BIT];
    end
  end

  // ===========================================================================
  // transmit clock and over-current pins: two flops before any logic
  logic [NCH-1:0] tclkS1, tclkS2, tclkPrev;
  logic [NCH-1:0] ocS1, ocS2;
  logic [8:0] tclkIdle [NCH];
  logic [NCH-1:0] tclkLost;
  logic [NCH-1:0] txFloat;

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      tclkS1 <= '0;
      tclkS2 <= '0;
      tclkPrev <= '0;
      ocS1 <= '0;
      ocS2 <= '0;
    end else begin
      tclkS1 <= txLineClockIn;
      tclkS2 <= tclkS1;
      tclkPrev <= tclkS2;
      ocS1 <= txOvercurrent;
      ocS2 <= ocS1;
    end
  end

  // idle counters saturate at the loss threshold; any edge clears them
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      for (int i = 0; i < NCH; i++) tclkIdle[i] <= '0;
      tclkLost <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (tclkS2[i] != tclkPrev[i]) begin
          tclkIdle[i] <= '0;
          tclkLost[i] <= 1'b0;
        end else if (tclkIdle[i] != TX_CLK_LOSS_CYCLES) begin
          tclkIdle[i] <= tclkIdle[i] + 9'h001;
        end else begin
          tclkLost[i] <= 1'b1;
        end
      end
    end
  end

  // per-channel transmit float decision, registered before it crosses
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      txFloat <= '1;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        txFloat[i] <= !txCfgA[i][TXA_OE_BIT]
          || txCfgA[i][TXA_OFF_BIT] || txMode[i][TXM_CH_RST_BIT]
          || (txCfgA[i][TXA_OC_FLOAT_BIT] && ocS2[i])
          || (txMode[i][TXM_NRZ_BIT] && tclkLost[i]
              && !txMode[i][TXM_REM_LOOP_BIT] && !txMode[i][TXM_INT_PAT_BIT]);
      end
    end
  end

  // ===========================================================================
  // internal timing clock: phase accumulator, mean rate exact, edges jitter by one mclk
  logic [17:0] ncoAcc;
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ncoAcc <= '0;
      internalTimingClock <= 1'b0;
    end else if (ncoAcc + NCO_STEP >= NCO_MOD) begin
      ncoAcc <= ncoAcc + NCO_STEP - NCO_MOD;
      internalTimingClock <= !internalTimingClock;
    end else begin
      ncoAcc <= ncoAcc + NCO_STEP;
    end
  end

  // ===========================================================================
  // heartbeat toggles slowly enough for the 15 ns link clock to see every change
  logic [1:0] hbDiv;
  logic heartbeat;
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      hbDiv <= '0;
      heartbeat <= 1'b0;
    end else begin
      hbDiv <= hbDiv + 2'h1;
      if (hbDiv == HEARTBEAT_DIV) heartbeat <= !heartbeat;
    end
  end

  // ===========================================================================
  // apb slave: one wait state, read data and error registered with pready
  logic [31:0] readData;
  logic addrHit;
  ltrx_rxcfg_s [NCH-1:0] rxCfgM;

  always_comb begin
    readData = 32'h0000_0000;
    addrHit = 1'b1;
    if (chanHit(paddr, RX_CFG_A_BASE)) readData = {24'h00_0000, rxCfgA[chanOf(paddr)]};
    else if (chanHit(paddr, RX_CFG_B_BASE)) readData = {24'h00_0000, rxCfgB[chanOf(paddr)]};
    else if (chanHit(paddr, TX_CFG_A_BASE)) readData = {24'h00_0000, txCfgA[chanOf(paddr)]};
    else if (chanHit(paddr, TX_MODE_BASE)) readData = {24'h00_0000, txMode[chanOf(paddr)]};
    else if (paddr == GLOBAL_CTRL_OFS) readData = {31'h0000_0000, lineEnable};
    else if (paddr == TX_FLOAT_STAT_OFS) readData = {10'h000, txFloat};
    else if (paddr == TX_CLK_LOST_STAT_OFS) readData = {10'h000, tclkLost};
    else if (paddr == OVERCURRENT_STAT_OFS) readData = {10'h000, ocS2};
    else addrHit = 1'b0;
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !addrHit;
      prdata <= (addrHit && !pwrite) ? readData : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

  // settings gathered into one packed carrier per channel before crossing
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      rxCfgM[i].rxOff = rxCfgA[i][RXA_OFF_BIT];
      rxCfgM[i].floatSel = rxCfgA[i][RXA_FLOAT_SEL_BIT];
      rxCfgM[i].invert = rxCfgB[i][RXB_INV_BIT];
      rxCfgM[i].fallEdge = rxCfgB[i][RXB_EDGE_BIT];
      rxCfgM[i].fmt = ltrx_fmt_e'(rxCfgB[i][RXB_FMT_LSB +: 2]);
    end
  end

  // ===========================================================================
  // crossings into the recovered clock domain; settings are quasi-static levels
  ltrx_rxcfg_s [NCH-1:0] rxCfgS1, rxCfgL;
  logic [NCH-1:0] txFloatS1, txFloatL;
  logic [4:0] lvlS1, lvlL; // heartbeat, line enable, impedance pin, enable pin, spare
  logic hbPrev;
  logic [4:0] mclkIdle;
  logic mclkLost;

  always_ff @(posedge recoveredRxClock or negedge linkRstN) begin
    if (!linkRstN) begin
      rxCfgS1 <= '0;
      rxCfgL <= '0;
      txFloatS1 <= '1;
      txFloatL <= '1;
      lvlS1 <= '0;
      lvlL <= '0;
    end else begin
      rxCfgS1 <= rxCfgM;
      rxCfgL <= rxCfgS1;
      txFloatS1 <= txFloat;
      txFloatL <= txFloatS1;
      lvlS1 <= {heartbeat, lineEnable, rxImpedancePin, txOutputEnablePin, 1'b0};
      lvlL <= lvlS1;
    end
  end

  // master clock watchdog, counted on the link clock since mclk cannot watch itself
  always_ff @(posedge recoveredRxClock or negedge linkRstN) begin
    if (!linkRstN) begin
      hbPrev <= 1'b0;
      mclkIdle <= '0;
      mclkLost <= 1'b0;
    end else begin
      hbPrev <= lvlL[4];
      if (lvlL[4] != hbPrev) begin
        mclkIdle <= '0;
        mclkLost <= 1'b0;
      end else if (mclkIdle != MCLK_LOSS_CYCLES) begin
        mclkIdle <= mclkIdle + 5'h01;
      end else begin
        mclkLost <= 1'b1;
      end
    end
  end

  // line-side float outputs; reset and a dead mclk both leave every pair floating
  always_ff @(posedge recoveredRxClock or negedge linkRstN) begin
    if (!linkRstN) begin
      rxLineHiZ <= '1;
      txLineOeN <= '1;
      rxDataOeN <= '1;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        rxLineHiZ[i] <= !lvlL[2] || mclkLost || !lvlL[3]
          || rxCfgL[i].rxOff;
        txLineOeN[i] <= !lvlL[1] || mclkLost || !lvlL[3]
          || txFloatL[i];
        rxDataOeN[i] <= rxCfgL[i].rxOff && rxCfgL[i].floatSel;
      end
    end
  end

  // ===========================================================================
  // receive data: one bank per clock edge; the active bank loads, the other copies the active bank or returns to the idle level (the invert setting, zero when off)
  logic [NCH-1:0] newPos, newNeg, idleLvl, isRz;
  logic [NCH-1:0] risePos, riseNeg, fallPos, fallNeg;
  logic riseMark, fallMark;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      isRz[i] = rxCfgL[i].fmt == FMT_DR_RZ || rxCfgL[i].fmt == FMT_DR_SLICED;
      idleLvl[i] = rxCfgL[i].rxOff ? 1'b0 : rxCfgL[i].invert;
      if (rxCfgL[i].rxOff) begin
        newPos[i] = 1'b0;
        newNeg[i] = 1'b0;
      end else if (rxCfgL[i].fmt == FMT_SR_NRZ) begin
        newPos[i] = rxDecodedData[i] ^ rxCfgL[i].invert;
        newNeg[i] = 1'b0;
      end else begin
        newPos[i] = rxPosRailIn[i] ^ rxCfgL[i].invert;
        newNeg[i] = rxNegRailIn[i] ^ rxCfgL[i].invert;
      end
    end
  end

  always_ff @(posedge recoveredRxClock or negedge linkRstN) begin
    if (!linkRstN) begin
      risePos <= '0;
      riseNeg <= '0;
      riseMark <= 1'b0;
    end else begin
      riseMark <= !riseMark;
      for (int i = 0; i < NCH; i++) begin
        if (!rxCfgL[i].fallEdge) begin
          risePos[i] <= newPos[i];
          riseNeg[i] <= newNeg[i];
        end else begin
          risePos[i] <= (isRz[i] || rxCfgL[i].rxOff) ? idleLvl[i] : fallPos[i];
          riseNeg[i] <= (isRz[i] || rxCfgL[i].rxOff) ? idleLvl[i] : fallNeg[i];
        end
      end
    end
  end

  always_ff @(negedge recoveredRxClock or negedge linkRstN) begin
    if (!linkRstN) begin
      fallPos <= '0;
      fallNeg <= '0;
      fallMark <= 1'b0;
    end else begin
      fallMark <= !fallMark;
      for (int i = 0; i < NCH; i++) begin
        if (rxCfgL[i].fallEdge) begin
          fallPos[i] <= newPos[i];
          fallNeg[i] <= newNeg[i];
        end else begin
          fallPos[i] <= (isRz[i] || rxCfgL[i].rxOff) ? idleLvl[i] : risePos[i];
          fallNeg[i] <= (isRz[i] || rxCfgL[i].rxOff) ? idleLvl[i] : riseNeg[i];
        end
      end
    end
  end

  // latest bank drives the pins; the falling bank toggles first after reset
  assign rxPosRailOut = (riseMark ^ fallMark) ? fallPos : risePos;
  assign rxNegRailOut = (riseMark ^ fallMark) ? fallNeg : riseNeg;
endmodule

// File: ltrx_line_ctrl_chk.sv
// port-level assertions for the line tristate and receive data output block
`timescale 1ns/1ps
module ltrx_line_ctrl_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic recoveredRxClock,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxImpedancePin,
  input wire logic txOutputEnablePin,
  input wire logic [ltrx_pkg::NCH-1:0] rxLineHiZ,
  input wire logic [ltrx_pkg::NCH-1:0] txLineOeN,
  input wire logic internalTimingClock
);
  import ltrx_pkg::*;
  // ==========================================================================
  // helper: half period of the internal clock in master clock cycles
  logic lastClk;
  logic seenEdge;
  logic [7:0] halfCnt;
  // first interval is skipped, it starts at an arbitrary accumulator phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lastClk <= 1'b0;
      seenEdge <= 1'b0;
      halfCnt <= 8'h00;
    end else begin
      lastClk <= internalTimingClock;
      seenEdge <= seenEdge | (internalTimingClock != lastClk);
      halfCnt <= (internalTimingClock != lastClk) ? 8'h01 : halfCnt + 8'h01;
    end
  end
  // ==========================================================================
  // link side float controls
  property p_rx_pin_float;
    @(posedge recoveredRxClock) disable iff (!rst_n) !rxImpedancePin [*4] |-> &rxLineHiZ;
  endproperty
  a_rx_pin_float: assert property (p_rx_pin_float) else $error("rx line driven with pin low");
  property p_tx_pin_float;
    @(posedge recoveredRxClock) disable iff (!rst_n) !txOutputEnablePin [*4] |-> &txLineOeN;
  endproperty
  a_tx_pin_float: assert property (p_tx_pin_float) else $error("tx line driven with pin low");
  property p_rst_float;
    @(posedge recoveredRxClock) disable iff (!rst_n) $rose(rst_n) |-> (&rxLineHiZ && &txLineOeN) [*3];
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("line driven right after reset");
  // ==========================================================================
  // internal timing clock: 200 MHz / 4.096 MHz gives 48 or 49 cycles a half
  property p_internal_timing_clock_half;
    @(posedge mclk) disable iff (!rst_n)
      (internalTimingClock != lastClk) && seenEdge |-> halfCnt inside {8'h30, 8'h31};
  endproperty
  a_internal_timing_clock_half: assert property (p_internal_timing_clock_half) else $error("internal clock half period wrong");
  // ==========================================================================
  // register bus handshake
  property p_apb_wait;
    @(posedge mclk) disable iff (!rst_n) psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("ready not after one wait state");
  property p_apb_pulse;
    @(posedge mclk) disable iff (!rst_n) pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("ready longer than one cycle");
  property p_apb_access;
    @(posedge mclk) disable iff (!rst_n) pready |-> psel && penable;
  endproperty
  a_apb_access: assert property (p_apb_access) else $error("ready outside access phase");
  property p_apb_idle;
    @(posedge mclk) disable iff (!rst_n) !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_apb_idle: assert property (p_apb_idle) else $error("read data or error without ready");
endmodule

bind ltrx_line_ctrl ltrx_line_ctrl_chk chk (
  .mclk(mclk), .rst_n(rst_n), .recoveredRxClock(recoveredRxClock), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxImpedancePin(rxImpedancePin), .txOutputEnablePin(txOutputEnablePin),
  .rxLineHiZ(rxLineHiZ), .txLineOeN(txLineOeN), .internalTimingClock(internalTimingClock)
);

// File: ltrx_line_ctrl_test.sv
// self-checking testbench of the line tristate and receive data output block
`timescale 1ns/1ps
module ltrx_line_ctrl_test;
  import ltrx_pkg::*;
  logic mclk = 1'b0;
  logic mclkRun = 1'b1;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic rxImpedancePin = 1'b1;
  logic txOutputEnablePin = 1'b1;
  logic [NCH-1:0] txLineClockIn = '0;
  logic [NCH-1:0] txClkRun = '1;
  logic [NCH-1:0] txOvercurrent = '0;
  logic recoveredRxClock;
  logic [NCH-1:0] rxDecodedData, rxPosRailIn, rxNegRailIn;
  logic [31:0] prdata;
  logic pready, pslverr, internalTimingClock;
  logic [NCH-1:0] rxLineHiZ, txLineOeN, rxPosRailOut, rxNegRailOut, rxDataOeN;
  int n_fail = 0, samples_checked = 0;
  int cycles = 0, xclkEdges = 0;
  localparam logic [NCH-1:0] ALL = '1;
  // ==========================================================================
  // clocks, transmit clock pins and run limit
  always #2.5 mclk = mclkRun ? ~mclk : mclk;
  always @(posedge mclk) txLineClockIn <= txLineClockIn ^ txClkRun;
  always @(posedge internalTimingClock) xclkEdges++;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end
  ltrx_rx_source src (.recoveredRxClock(recoveredRxClock), .rxDecodedData(rxDecodedData),
    .rxPosRailIn(rxPosRailIn), .rxNegRailIn(rxNegRailIn));
  ltrx_line_ctrl dut (.mclk(mclk), .rst_n(rst_n), .recoveredRxClock(recoveredRxClock),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxImpedancePin(rxImpedancePin),
    .txOutputEnablePin(txOutputEnablePin), .txLineClockIn(txLineClockIn),
    .txOvercurrent(txOvercurrent), .rxDecodedData(rxDecodedData), .rxPosRailIn(rxPosRailIn),
    .rxNegRailIn(rxNegRailIn), .rxLineHiZ(rxLineHiZ), .txLineOeN(txLineOeN),
    .rxPosRailOut(rxPosRailOut), .rxNegRailOut(rxNegRailOut), .rxDataOeN(rxDataOeN),
    .internalTimingClock(internalTimingClock));
  // ==========================================================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // setup then access, held until ready is sampled high; waits are cut only by the run limit
  task automatic apb(logic wr, logic [AW-1:0] a, logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [AW-1:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdchk(string what, logic [AW-1:0] a, logic [31:0] exp, logic expErr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, r, exp);
    check({what, " err"}, e, expErr);
  endtask
  task automatic cfg_all(logic [AW-1:0] base, logic [31:0] v);
    for (int c = 0; c < NCH; c++) wr(base + AW'(4 * c), v);
  endtask
  task automatic lwait(int n);
    repeat (n) @(posedge recoveredRxClock);
    #1;
  endtask
  // ==========================================================================
  // scenarios
  task automatic test_reset();
    check("rx hiz in reset", rxLineHiZ, ALL);
    check("tx oe in reset", txLineOeN, ALL);
    rst_n <= 1'b1;
    lwait(8);
    check("rx hiz after reset", rxLineHiZ, ALL);
    check("tx oe after reset", txLineOeN, ALL);
    rdchk("global reset value", GLOBAL_CTRL_OFS, 32'h0, 1'b0);
    rdchk("rx cfg b reset value", RX_CFG_B_BASE + 12'h054, 32'h0, 1'b0);
    wr(RX_CFG_B_BASE + 12'h054, 32'hFFFFFF5A);
    rdchk("upper bits", RX_CFG_B_BASE + 12'h054, 32'h5A, 1'b0);
    rdchk("unmapped", 12'h300, 32'h0, 1'b1);
    rdchk("channel 22", RX_CFG_A_BASE + 12'h058, 32'h0, 1'b1);
    rdchk("unaligned", 12'h202, 32'h0, 1'b1);
    wr(OVERCURRENT_STAT_OFS, 32'hFFFFFFFF);
    rdchk("status read only", OVERCURRENT_STAT_OFS, 32'h0, 1'b0);
    $display("reset and register test done");
  endtask
  task automatic test_enable();
    wr(GLOBAL_CTRL_OFS, 32'h1);
    cfg_all(RX_CFG_B_BASE, 32'h0);
    cfg_all(TX_CFG_A_BASE, 32'h40);
    lwait(6);
    check("tx driven", txLineOeN, 32'h0);
    check("rx driven", rxLineHiZ, 32'h0);
    @(posedge mclk);
    rxImpedancePin <= 1'b0;
    txOutputEnablePin <= 1'b0;
    lwait(6);
    check("rx pin float", rxLineHiZ, ALL);
    check("tx pin float", txLineOeN, ALL);
    @(posedge mclk);
    rxImpedancePin <= 1'b1;
    txOutputEnablePin <= 1'b1;
    lwait(6);
    check("tx pin release", txLineOeN, 32'h0);
    $display("global enable test done");
  endtask
  // ch3/4 receiver off, ch5 no enable, ch6 tx off, ch7 channel reset, ch8/9 over-current,
  // ch10..12 NRZ with stopped transmit clock, ch11 loopback, ch12 internal pattern
  task automatic test_channels();
    wr(RX_CFG_A_BASE + 12'h00C, 32'h20);
    wr(RX_CFG_A_BASE + 12'h010, 32'h60);
    wr(TX_CFG_A_BASE + 12'h014, 32'h00);
    wr(TX_CFG_A_BASE + 12'h018, 32'h60);
    wr(TX_MODE_BASE + 12'h01C, 32'h08);
    wr(TX_CFG_A_BASE + 12'h020, 32'h50);
    wr(TX_MODE_BASE + 12'h028, 32'h01);
    wr(TX_MODE_BASE + 12'h02C, 32'h03);
    wr(TX_MODE_BASE + 12'h030, 32'h05);
    txOvercurrent <= 22'h000300;
    txClkRun <= ~22'h001C00;
    repeat (320) @(posedge mclk);
    check("rx off float", rxLineHiZ, 22'h000018);
    check("rx data float", rxDataOeN, 22'h000010);
    check("rx off low", rxPosRailOut[4:3], 2'b00);
    check("tx channel float", txLineOeN, 22'h0005E0);
    rdchk("clock lost status", TX_CLK_LOST_STAT_OFS, 32'h1C00, 1'b0);
    rdchk("overcurrent status", OVERCURRENT_STAT_OFS, 32'h300, 1'b0);
    txOvercurrent <= '0;
    txClkRun <= '1;
    cfg_all(TX_MODE_BASE, 32'h0);
    cfg_all(TX_CFG_A_BASE, 32'h40);
    cfg_all(RX_CFG_A_BASE, 32'h0);
    lwait(6);
    check("tx all back", txLineOeN, 32'h0);
    $display("per channel test done");
  endtask
  task automatic rail_chk(logic fall, logic dual, logic rz, logic [NCH-1:0] inv);
    logic [NCH-1:0] p, n;
    if (fall) @(negedge recoveredRxClock);
    else @(posedge recoveredRxClock);
    p = dual ? rxPosRailIn : rxDecodedData;
    n = dual ? rxNegRailIn : '0;
    #3;
    check("pos rail", rxPosRailOut, p ^ inv);
    check("neg rail", rxNegRailOut, dual ? n ^ inv : '0);
    #5;
    check("pos rail after", rxPosRailOut, rz ? inv : p ^ inv);
    check("neg rail after", rxNegRailOut, !dual ? '0 : rz ? inv : n ^ inv);
  endtask
  task automatic test_rx_formats();
    for (int m = 0; m < 16; m++) begin
      cfg_all(RX_CFG_B_BASE, {27'h0, m[3], m[2], 1'b0, m[1:0]});
      lwait(6);
      repeat (3) rail_chk(m[3], m[1:0] != 2'b00, m[1], {NCH{m[2]}});
    end
    $display("receive format test done");
  endtask
  task automatic test_clocks();
    xclkEdges = 0;
    repeat (2000) @(posedge mclk);
    check("internal clock edges", 32'(xclkEdges == 20 || xclkEdges == 21), 32'h1);
    mclkRun <= 1'b0;
    lwait(30);
    check("mclk lost rx", rxLineHiZ, ALL);
    check("mclk lost tx", txLineOeN, ALL);
    mclkRun <= 1'b1;
    lwait(12);
    check("mclk back", txLineOeN, 32'h0);
    wr(GLOBAL_CTRL_OFS, 32'h3);
    lwait(6);
    check("sw reset tx", txLineOeN, ALL);
    check("sw reset rx", rxLineHiZ, ALL);
    rdchk("sw reset clears", GLOBAL_CTRL_OFS, 32'h0, 1'b0);
    $display("clock and software reset test done");
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    test_reset();
    test_enable();
    test_channels();
    test_rx_formats();
    test_clocks();
    close_out();
  end
endmodule

// File: ltrx_pkg.sv
// constants, types and register map of the line tristate and receive data output block
package ltrx_pkg;
  // ===========================================================================
  // sizes
  localparam int NCH = 22;
  localparam int AW = 12;
  // ===========================================================================
  // register map, byte addresses; per-channel blocks step by one word
  localparam logic [AW-1:0] RX_CFG_A_BASE = 12'h000;
  localparam logic [AW-1:0] RX_CFG_B_BASE = 12'h080;
  localparam logic [AW-1:0] TX_CFG_A_BASE = 12'h100;
  localparam logic [AW-1:0] TX_MODE_BASE = 12'h180;
  localparam logic [AW-1:0] GLOBAL_CTRL_OFS = 12'h200;
  localparam logic [AW-1:0] TX_FLOAT_STAT_OFS = 12'h204;
  localparam logic [AW-1:0] TX_CLK_LOST_STAT_OFS = 12'h208;
  localparam logic [AW-1:0] OVERCURRENT_STAT_OFS = 12'h20C;
  // ===========================================================================
  // field positions
  localparam int RXA_OFF_BIT = 5;
  localparam int RXA_FLOAT_SEL_BIT = 6;
  localparam int RXB_FMT_LSB = 0;
  localparam int RXB_INV_BIT = 3;
  localparam int RXB_EDGE_BIT = 4;
  localparam int TXA_OC_FLOAT_BIT = 4;
  localparam int TXA_OFF_BIT = 5;
  localparam int TXA_OE_BIT = 6;
  localparam int TXM_NRZ_BIT = 0;
  localparam int TXM_REM_LOOP_BIT = 1;
  localparam int TXM_INT_PAT_BIT = 2;
  localparam int TXM_CH_RST_BIT = 3;
  localparam int GC_LINE_EN_BIT = 0;
  localparam int GC_SW_RST_BIT = 1;
  // ===========================================================================
  // values after reset
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic GC_LINE_EN_RESET = 1'b0;
  // ===========================================================================
  // clock rates and cycle counts
  localparam int MCLK_FREQ_KHZ = 200000;
  localparam int INTERNAL_TIMING_CLOCK_FREQ_KHZ = 2048;
  localparam logic [17:0] NCO_MOD = 18'(MCLK_FREQ_KHZ);
  localparam logic [17:0] NCO_STEP = 18'(2 * INTERNAL_TIMING_CLOCK_FREQ_KHZ);
  localparam logic [8:0] TX_CLK_LOSS_CYCLES = 9'h100;
  localparam logic [1:0] HEARTBEAT_DIV = 2'h3;
  localparam logic [4:0] MCLK_LOSS_CYCLES = 5'h10;
  // ===========================================================================
  // receive system-side formats
  typedef enum logic [1:0] {
    FMT_SR_NRZ = 2'b00,
    FMT_DR_NRZ = 2'b01,
    FMT_DR_RZ = 2'b10,
    FMT_DR_SLICED = 2'b11
  } ltrx_fmt_e;
  // per-channel receive settings carried to the recovered-clock side
  typedef struct packed {
    logic rxOff;
    logic floatSel;
    logic invert;
    logic fallEdge;
    ltrx_fmt_e fmt;
  } ltrx_rxcfg_s;
endpackage

// File: ltrx_rx_source.sv
// behavioural line-side source: recovered clock and received symbols per channel
`timescale 1ns/1ps
module ltrx_rx_source (
  output logic recoveredRxClock,
  output logic [ltrx_pkg::NCH-1:0] rxDecodedData,
  output logic [ltrx_pkg::NCH-1:0] rxPosRailIn,
  output logic [ltrx_pkg::NCH-1:0] rxNegRailIn
);
  import ltrx_pkg::*;
  logic [NCH-1:0] pattern = 22'h2D3A65;
  // recovered clock runs free while a line signal is present; phase unrelated to mclk
  initial begin
    recoveredRxClock = 1'b0;
    #3.3;
    forever #7.5 recoveredRxClock = ~recoveredRxClock;
  end
  // new symbol at each rising edge, so a falling active edge sees settled data
  always @(posedge recoveredRxClock) begin
    pattern <= {pattern[NCH-2:0], pattern[NCH-1] ^ pattern[0]};
  end
  // decoded data differs from the rails; a symbol never marks both rails
  assign rxDecodedData = pattern ^ {pattern[10:0], pattern[NCH-1:11]};
  assign rxPosRailIn = pattern;
  assign rxNegRailIn = ~pattern & {pattern[0], pattern[NCH-1:1]};
endmodule
